// ---- rftc_regs.sv ----
// RF transmitter control and status registers on the core I/O space
// Notes on behaviour
// - Hold bit high keeps unlock counter in reset, disabling slip-based unlock detection.
// - Hold is level sensitive; unlock counter advances only while hold is zero.
// - With key blackout enabled, key rising edge starts blackout ignoring slips.
// - Blackout disabled counts slips at once, but only while lock is asserted.
// - Slip field codes 0..3 unlock on the first to fourth counted slip.
// - No slip counts unless blackout disabled or blackout window expired.
// - Synth enable bit turns the PLL synthesizer on; clearing turns it off.
// - Amp key bit turns on the power amplifier, keying the carrier.
// - Read-only lock status bit is set while the synthesizer is locked.
// - Applied attenuation is coarse setting plus fine setting.
// - Coarse field bits 5:3 steps 6 dB, codes 0..5; 6 and 7 invalid.
// - Fine field bits 2:0 steps 1 dB, codes 0..5; 6 and 7 invalid.
// - All-zero attenuation bits select maximum output power.
// - Five-bit tank code switches capacitance linearly, 0.03 pF per step.
// - Window comparator outputs read back as bits 7 and 6 of tuning reg.
// - Window code 00 inside, 01 below, 10 above; 11 never valid.
// - Registers at 0x00..0x1F support bit set, clear and test.
// - Blackout lasts 8 to 1024 reference clocks; restarts on key, lock, hold.
// - Lock asserts after 8 to 1024 reference clocks; restarts on faults.
module rftc_regs
  import rftc_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Core I/O access
  input  rftc_req_t         io_req,
  output logic [7:0]        io_rdata,
  output logic              io_bit_test,
  // PLL and comparator inputs
  input  wire logic         ref_tick,
  input  wire logic         cycle_slip,
  input  wire logic         phase_unlocked,
  input  wire logic         ref_too_low,
  input  wire logic [1:0]   ctrl_voltage_window,
  // Analog controls
  output rftc_analog_t      analog_ctrl
);

  logic [7:0]   lock_cfg_reg;
  logic [7:0]   tx_ctrl_reg;
  logic [7:0]   atten_reg;
  logic [4:0]   tune_reg;
  logic [7:0]   lock_cfg2_reg;
  logic [1:0]   win_reg;
  logic         lock_stat;
  logic [7:0]   rdata_reg;
  logic         bit_test_reg;
  rftc_analog_t analog_reg;
  rftc_analog_t analog_next;

  // Dest value for an access: byte write, or one bit set or cleared
  function automatic logic [7:0] apply_op(input rftc_req_t r, input logic [7:0] cur,
                                          input logic [7:0] mask);
    logic [7:0] v;
    v = cur;
    unique case (r.op)
      RFTC_OP_WRITE: v = r.wdata;
      RFTC_OP_SET:   v = cur | (8'h01 << r.bit_sel);
      RFTC_OP_CLEAR: v = cur & ~(8'h01 << r.bit_sel);
      default:       v = cur;
    endcase
    apply_op = v & mask;
  endfunction : apply_op

  // Bit ops only reach the lower bit-addressable window
  wire bit_op    = (io_req.op == RFTC_OP_SET) | (io_req.op == RFTC_OP_CLEAR);
  wire op_ok     = ~bit_op | (io_req.addr <= RFTC_BIT_OP_LIMIT);
  wire wr_any    = ((io_req.op == RFTC_OP_WRITE) | bit_op) & op_ok;
  wire wr_lock   = wr_any & (io_req.addr == RFTC_LOCK_CFG_ADDR);
  wire wr_tx     = wr_any & (io_req.addr == RFTC_TX_CTRL_ADDR);
  wire wr_atten  = wr_any & (io_req.addr == RFTC_ATTEN_ADDR);
  wire wr_tune   = wr_any & (io_req.addr == RFTC_TUNE_ADDR);
  wire wr_lock2  = wr_any & (io_req.addr == RFTC_LOCK_CFG2_ADDR);
  // Tuning write image; only the low five bits are stored
  wire [7:0] tune_new = apply_op(io_req, {3'h0, tune_reg}, RFTC_TUNE_MASK);

  // Live readback image; lock and window status merged in
  wire [7:0] tx_view   = tx_ctrl_reg | (8'(lock_stat) << RFTC_LOCK_BIT);
  wire [7:0] tune_view = {win_reg, 1'b0, tune_reg};
  wire [7:0] rd_mux    = (io_req.addr == RFTC_LOCK_CFG_ADDR)  ? lock_cfg_reg  :
                         (io_req.addr == RFTC_TX_CTRL_ADDR)   ? tx_view       :
                         (io_req.addr == RFTC_ATTEN_ADDR)     ? atten_reg     :
                         (io_req.addr == RFTC_TUNE_ADDR)      ? tune_view     :
                         (io_req.addr == RFTC_LOCK_CFG2_ADDR) ? lock_cfg2_reg : 8'h00;

  // Control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_cfg_reg  <= RFTC_LOCK_CFG_RST;
      tx_ctrl_reg   <= RFTC_TX_CTRL_RST;
      atten_reg     <= RFTC_ATTEN_RST;
      tune_reg      <= RFTC_TUNE_RST;
      lock_cfg2_reg <= RFTC_LOCK_CFG2_RST;
    end else begin
      if (wr_lock)  lock_cfg_reg  <= apply_op(io_req, lock_cfg_reg, RFTC_LOCK_CFG_MASK);
      if (wr_tx)    tx_ctrl_reg   <= apply_op(io_req, tx_ctrl_reg, RFTC_TX_CTRL_MASK);
      if (wr_atten) atten_reg     <= apply_op(io_req, atten_reg, RFTC_ATTEN_MASK);
      if (wr_tune)  tune_reg      <= tune_new[4:0];
      if (wr_lock2) lock_cfg2_reg <= apply_op(io_req, lock_cfg2_reg, 8'hFF);
    end
  end

  // Comparator sample; cleared to 00 by reset, then taken every clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) win_reg <= 2'h0;
    else     win_reg <= ctrl_voltage_window;
  end

  // Read data and bit-test result, one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg    <= 8'h00;
      bit_test_reg <= 1'b0;
    end else begin
      rdata_reg    <= (io_req.op == RFTC_OP_READ) ? rd_mux : rdata_reg;
      bit_test_reg <= rd_mux[io_req.bit_sel] & (io_req.addr <= RFTC_BIT_OP_LIMIT);
    end
  end

  // Lock/unlock detector
  rftc_lock_det u_lock_det (
    .clk                      (clk),
    .rst                      (rst),
    .ref_tick                 (ref_tick),
    .cycle_slip               (cycle_slip),
    .phase_unlocked           (phase_unlocked),
    .ref_too_low              (ref_too_low),
    .synth_enable             (tx_ctrl_reg[RFTC_SYNTH_EN_BIT]),
    .amp_key                  (tx_ctrl_reg[RFTC_AMP_KEY_BIT]),
    .unlock_counter_hold      (lock_cfg_reg[RFTC_HOLD_BIT]),
    .key_edge_blackout_enable (lock_cfg_reg[RFTC_KEY_BO_BIT]),
    .blackout_disable         (lock_cfg_reg[RFTC_BO_DIS_BIT]),
    .slip_limit               (lock_cfg_reg[1:0]),
    .blackout_length          (lock_cfg2_reg[5:3]),
    .lock_delay_length        (lock_cfg2_reg[2:0]),
    .lock_force               (lock_cfg2_reg[6]),
    .lock_detect              (lock_stat)
  );

  // Analog control decode; invalid codes flagged, not clamped
  wire [2:0] coarse_atten = atten_reg[5:3];
  wire [2:0] fine_atten   = atten_reg[2:0];
  always_comb begin
    analog_next.synth_on      = tx_ctrl_reg[RFTC_SYNTH_EN_BIT];
    analog_next.amp_on        = tx_ctrl_reg[RFTC_AMP_KEY_BIT];
    analog_next.atten_db      = 6'(coarse_atten * RFTC_COARSE_STEP_DB) + 6'(fine_atten);
    analog_next.atten_invalid = (coarse_atten > RFTC_ATTEN_CODE_MAX) |
                                (fine_atten > RFTC_ATTEN_CODE_MAX);
    analog_next.tank_cap_code = tune_reg;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) analog_reg <= '0;
    else     analog_reg <= analog_next;
  end

  assign io_rdata    = rdata_reg;
  assign io_bit_test = bit_test_reg;
  assign analog_ctrl = analog_reg;

  // Checks
  chk_atten_sum: assert property (@(posedge clk) disable iff (rst)
    ##1 analog_ctrl.atten_db == 6'($past(coarse_atten) * 6) + 6'($past(fine_atten)))
    else $error("attenuation not coarse plus fine");
  chk_zero_atten: assert property (@(posedge clk) disable iff (rst)
    atten_reg[5:0] == 6'h00 |=> analog_ctrl.atten_db == 6'h00)
    else $error("zero code did not give full power");
  chk_synth_follow: assert property (@(posedge clk) disable iff (rst)
    wr_tx && io_req.op == RFTC_OP_WRITE |=> ##1 analog_ctrl.synth_on == $past(io_req.wdata[5], 2))
    else $error("synth enable not applied");
  chk_amp_follow: assert property (@(posedge clk) disable iff (rst)
    wr_tx && io_req.op == RFTC_OP_SET && io_req.bit_sel == 3'h4 |=> ##1 analog_ctrl.amp_on)
    else $error("amp key set not applied");
  chk_hold_no_lock: assert property (@(posedge clk) disable iff (rst)
    !lock_cfg2_reg[6] && lock_cfg_reg[4] && !lock_stat |=> !lock_stat || !cycle_slip)
    else $error("lock rose while held with slip");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    lock_cfg_reg[7:5] == 3'h0 && tx_ctrl_reg[7:6] == 2'h0 && atten_reg[7:6] == 2'h0)
    else $error("reserved bit stored");
  chk_window_read: assert property (@(posedge clk) disable iff (rst)
    io_req.op == RFTC_OP_READ && io_req.addr == RFTC_TUNE_ADDR |=> io_rdata[7:6] == $past(win_reg))
    else $error("window bits not read back");
  chk_lock_read: assert property (@(posedge clk) disable iff (rst)
    io_req.op == RFTC_OP_READ && io_req.addr == RFTC_TX_CTRL_ADDR |=> io_rdata[2] == $past(lock_stat))
    else $error("lock status not read back");
  chk_bit_limit: assert property (@(posedge clk) disable iff (rst)
    bit_op && io_req.addr > RFTC_BIT_OP_LIMIT |-> !wr_any)
    else $error("bit op above window accepted");

  cov_lock_up:   cover property (@(posedge clk) disable iff (rst) $rose(lock_stat));
  cov_lock_drop: cover property (@(posedge clk) disable iff (rst) $fell(lock_stat));
  cov_bit_set:   cover property (@(posedge clk) disable iff (rst) wr_atten && io_req.op == RFTC_OP_SET);
  cov_invalid:   cover property (@(posedge clk) disable iff (rst) analog_ctrl.atten_invalid);

endmodule : rftc_regs

// ---- rftc_pkg.sv ----
// Package: register map, field layout, reset values and shared types of the RF transmitter regs
package rftc_pkg;

  // Register offsets in I/O space
  localparam logic [5:0] RFTC_LOCK_CFG_ADDR  = 6'h10;
  localparam logic [5:0] RFTC_TX_CTRL_ADDR   = 6'h12;
  localparam logic [5:0] RFTC_ATTEN_ADDR     = 6'h14;
  localparam logic [5:0] RFTC_TUNE_ADDR      = 6'h16;
  localparam logic [5:0] RFTC_LOCK_CFG2_ADDR = 6'h17;
  localparam logic [5:0] RFTC_BIT_OP_LIMIT   = 6'h1F;

  // Reset values
  localparam logic [7:0] RFTC_LOCK_CFG_RST  = 8'h00;
  localparam logic [7:0] RFTC_TX_CTRL_RST   = 8'h00;
  localparam logic [7:0] RFTC_ATTEN_RST     = 8'h00;
  localparam logic [4:0] RFTC_TUNE_RST      = 5'h00;
  localparam logic [7:0] RFTC_LOCK_CFG2_RST = 8'h00;

  // Writable bit masks; reserved bits stay zero
  localparam logic [7:0] RFTC_LOCK_CFG_MASK = 8'h1F;
  localparam logic [7:0] RFTC_TX_CTRL_MASK  = 8'h30;
  localparam logic [7:0] RFTC_ATTEN_MASK    = 8'h3F;
  localparam logic [7:0] RFTC_TUNE_MASK     = 8'h1F;

  // Field positions
  localparam int RFTC_HOLD_BIT     = 4;
  localparam int RFTC_KEY_BO_BIT   = 3;
  localparam int RFTC_BO_DIS_BIT   = 2;
  localparam int RFTC_SYNTH_EN_BIT = 5;
  localparam int RFTC_AMP_KEY_BIT  = 4;
  localparam int RFTC_LOCK_BIT     = 2;
  localparam int RFTC_WIN_LSB      = 6;

  // Attenuation limits and steps in dB
  localparam logic [2:0] RFTC_ATTEN_CODE_MAX = 3'h5;
  localparam logic [5:0] RFTC_COARSE_STEP_DB = 6'h06;

  // Lock/unlock delay base in reference clocks
  localparam int RFTC_DELAY_BASE_LOG2 = 3;

  // I/O access operations from the core
  typedef enum logic [2:0] {
    RFTC_OP_NONE  = 3'b000,
    RFTC_OP_WRITE = 3'b001,
    RFTC_OP_READ  = 3'b010,
    RFTC_OP_SET   = 3'b011,
    RFTC_OP_CLEAR = 3'b100
  } rftc_op_t;

  // Core-side request carrier
  typedef struct packed {
    rftc_op_t   op;
    logic [5:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } rftc_req_t;

  // Analog controls carrier
  typedef struct packed {
    logic       synth_on;
    logic       amp_on;
    logic [5:0] atten_db;
    logic       atten_invalid;
    logic [4:0] tank_cap_code;
  } rftc_analog_t;

endpackage : rftc_pkg

// ---- rftc_lock_det.sv ----
// PLL lock and unlock detector with blackout window and cycle-slip counter
module rftc_lock_det
  import rftc_pkg::*;
#(
  parameter int CNT_W = 11
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Reference clock tick and PLL events
  input  wire logic       ref_tick,
  input  wire logic       cycle_slip,
  input  wire logic       phase_unlocked,
  input  wire logic       ref_too_low,
  // Configuration
  input  wire logic       synth_enable,
  input  wire logic       amp_key,
  input  wire logic       unlock_counter_hold,
  input  wire logic       key_edge_blackout_enable,
  input  wire logic       blackout_disable,
  input  wire logic [1:0] slip_limit,
  input  wire logic [2:0] blackout_length,
  input  wire logic [2:0] lock_delay_length,
  input  wire logic       lock_force,
  // Lock status
  output logic            lock_detect
);

  logic [CNT_W-1:0] lock_cnt_reg;
  logic [CNT_W-1:0] bo_cnt_reg;
  logic [1:0]       slip_cnt_reg;
  logic             bo_done_reg;
  logic             lock_reg;
  logic             key_d_reg;
  logic             lock_d_reg;

  // Delay in reference clocks for a 3-bit length code
  function automatic logic [CNT_W-1:0] delay_of(input logic [2:0] code);
    delay_of = CNT_W'(1) << (RFTC_DELAY_BASE_LOG2 + int'(code));
  endfunction : delay_of

  wire key_rise    = amp_key & ~key_d_reg;
  wire lock_rise   = lock_reg & ~lock_d_reg;
  // Blackout restarts on key edge, lock rise, or while held
  wire bo_restart  = unlock_counter_hold | (key_rise & key_edge_blackout_enable) | lock_rise;
  // Slips count only outside blackout and while locked
  wire slip_open   = (blackout_disable | bo_done_reg) & lock_reg & ~unlock_counter_hold;
  wire slip_hit    = cycle_slip & slip_open;
  wire slip_trip   = slip_hit & (slip_cnt_reg == slip_limit);
  // A slip restarts only the lock count; once locked, slips go through the slip counter
  wire lock_clear  = ~synth_enable | (cycle_slip & ~lock_reg) | phase_unlocked | ref_too_low;
  wire lock_reach  = ref_tick & (lock_cnt_reg == delay_of(lock_delay_length) - CNT_W'(1));

  // Edge history for key and lock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_d_reg  <= 1'b0;
      lock_d_reg <= 1'b0;
    end else begin
      key_d_reg  <= amp_key;
      lock_d_reg <= lock_reg;
    end
  end

  // Lock counter; a tripped slip count also drops lock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_cnt_reg <= '0;
      lock_reg     <= 1'b0;
    end else if (lock_clear | slip_trip) begin
      lock_cnt_reg <= '0;
      lock_reg     <= 1'b0;
    end else if (lock_reach) begin
      lock_reg <= 1'b1;
    end else if (ref_tick & ~lock_reg) begin
      lock_cnt_reg <= lock_cnt_reg + CNT_W'(1);
    end
  end

  // Blackout counter and slip counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bo_cnt_reg   <= '0;
      bo_done_reg  <= 1'b0;
      slip_cnt_reg <= 2'h0;
    end else if (bo_restart | ~lock_reg) begin
      bo_cnt_reg   <= '0;
      bo_done_reg  <= 1'b0;
      slip_cnt_reg <= 2'h0;
    end else begin
      if (ref_tick & ~bo_done_reg) begin
        bo_cnt_reg  <= bo_cnt_reg + CNT_W'(1);
        bo_done_reg <= (bo_cnt_reg == delay_of(blackout_length) - CNT_W'(1));
      end
      if (slip_hit & ~slip_trip) slip_cnt_reg <= slip_cnt_reg + 2'h1;
    end
  end

  // Force keeps lock status reading high whatever the detector state
  assign lock_detect = lock_reg | lock_force;

endmodule : rftc_lock_det

// ---- rftc_pll_model.sv ----
// Behavioural PLL and comparator side facing the transmitter register block
module rftc_pll_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bench commands
  input  wire logic       slip_cmd,
  input  wire logic [1:0] window_cmd,
  // PLL events and comparator code
  output logic            ref_tick,
  output logic            cycle_slip,
  output logic            phase_unlocked,
  output logic            ref_too_low,
  output logic [1:0]      ctrl_voltage_window
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg;

  // Reference tick every fourth clock keeps lock delays short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg    <= 2'h0;
      cycle_slip <= 1'b0;
      ctrl_voltage_window <= 2'h0;
    end else begin
      div_reg    <= div_reg + 2'h1;
      cycle_slip <= slip_cmd;
      ctrl_voltage_window <= window_cmd;
    end
  end
  assign ref_tick       = (div_reg == 2'h3);
  // Healthy reference and loop; faults come only as slips
  assign phase_unlocked = 1'b0;
  assign ref_too_low    = 1'b0;
endmodule : rftc_pll_model

// ---- rftc_regs_tb.sv ----
// Self-checking bench for the RF transmitter control registers
module rftc_regs_tb
  import rftc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  rftc_req_t    io_req;
  logic [7:0]   io_rdata;
  logic         io_bit_test;
  logic         ref_tick, cycle_slip, phase_unlocked, ref_too_low;
  logic [1:0]   ctrl_voltage_window, win;
  logic         slip_cmd;
  rftc_analog_t analog_ctrl;
  int           miscompares = 0;
  int           checked = 0;
  int           cycles = 0;

  rftc_regs rftc_regs_inst (.clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
    .io_bit_test(io_bit_test), .ref_tick(ref_tick), .cycle_slip(cycle_slip),
    .phase_unlocked(phase_unlocked), .ref_too_low(ref_too_low),
    .ctrl_voltage_window(ctrl_voltage_window), .analog_ctrl(analog_ctrl));
  rftc_pll_model rftc_pll_model_inst (.clk(clk), .rst(rst), .slip_cmd(slip_cmd),
    .window_cmd(win), .ref_tick(ref_tick), .cycle_slip(cycle_slip),
    .phase_unlocked(phase_unlocked), .ref_too_low(ref_too_low),
    .ctrl_voltage_window(ctrl_voltage_window));

  always #20 clk = ~clk;

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Hang guard; the full run needs under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle request, then two edges so data and analog outputs settle
  task automatic access(input rftc_op_t op, input logic [5:0] a, input logic [2:0] b,
                        input logic [7:0] d);
    @(posedge clk);
    #1 io_req = '{op, a, b, d};
    @(posedge clk);
    #1 io_req.op = RFTC_OP_NONE;
    @(posedge clk);
    #1;
  endtask : access

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    access(RFTC_OP_WRITE, a, 3'h0, d);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    access(RFTC_OP_READ, a, 3'h0, 8'h00);
    chk(io_rdata, exp);
  endtask : rd

  task automatic slip();
    @(posedge clk);
    #1 slip_cmd = 1'b1;
    @(posedge clk);
    #1 slip_cmd = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : slip

  // Software polls lock before keying the amplifier
  task automatic wait_lock();
    for (int n = 0; n < 100; n++) begin
      access(RFTC_OP_READ, RFTC_TX_CTRL_ADDR, 3'h0, 8'h00);
      if (io_rdata[2] === 1'b1) break;
    end
    chk(io_rdata & 8'h04, 8'h04);
  endtask : wait_lock

  initial begin
    io_req   = '0;
    slip_cmd = 1'b0;
    win      = 2'h0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    // Reset values and reserved bits
    chk(analog_ctrl[7:0], 8'h00);
    rd(RFTC_LOCK_CFG_ADDR, 8'h00);
    rd(RFTC_TX_CTRL_ADDR, 8'h00);
    rd(RFTC_ATTEN_ADDR, 8'h00);
    rd(RFTC_TUNE_ADDR, 8'h00);
    rd(RFTC_LOCK_CFG2_ADDR, 8'h00);
    wr(RFTC_LOCK_CFG_ADDR, 8'hFF);
    rd(RFTC_LOCK_CFG_ADDR, 8'h1F);
    wr(6'h11, 8'hFF);
    rd(6'h11, 8'h00);
    wr(RFTC_LOCK_CFG_ADDR, 8'h00);
    $display("test reset_map done");
    // Every coarse and fine code, invalid ones included
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 8; f++) begin
        wr(RFTC_ATTEN_ADDR, {2'b11, 3'(c), 3'(f)});
        chk({2'h0, analog_ctrl.atten_db}, 8'(c * 6 + f));
        chk({7'h0, analog_ctrl.atten_invalid}, {7'h0, (c > 5) || (f > 5)});
        rd(RFTC_ATTEN_ADDR, {2'b00, 3'(c), 3'(f)});
      end
    end
    $display("test attenuation done");
    // Tank code and comparator code readback
    wr(RFTC_TUNE_ADDR, 8'hFF);
    chk({3'h0, analog_ctrl.tank_cap_code}, 8'h1F);
    for (int w = 0; w < 3; w++) begin
      win = 2'(w);
      repeat (2) @(posedge clk);
      rd(RFTC_TUNE_ADDR, {2'(w), 6'h1F});
    end
    wr(RFTC_TUNE_ADDR, 8'h00);
    chk({3'h0, analog_ctrl.tank_cap_code}, 8'h00);
    $display("test tuning done");
    // Bit set, clear and test
    access(RFTC_OP_SET, RFTC_TX_CTRL_ADDR, 3'h5, 8'h00);
    chk({7'h0, io_bit_test}, 8'h01);
    chk({7'h0, analog_ctrl.synth_on}, 8'h01);
    access(RFTC_OP_CLEAR, RFTC_TX_CTRL_ADDR, 3'h5, 8'h00);
    chk({7'h0, io_bit_test}, 8'h00);
    chk({7'h0, analog_ctrl.synth_on}, 8'h00);
    rd(6'h20, 8'h00);
    chk({7'h0, io_bit_test}, 8'h00);
    $display("test bit_ops done");
    // Lock, keying and slip counting; synth stays on while keying
    wr(RFTC_TX_CTRL_ADDR, 8'hE0);
    wait_lock();
    access(RFTC_OP_SET, RFTC_TX_CTRL_ADDR, 3'h4, 8'h00);
    chk({7'h0, analog_ctrl.amp_on}, 8'h01);
    rd(RFTC_TX_CTRL_ADDR, 8'h34);
    wr(RFTC_LOCK_CFG_ADDR, 8'h05);
    slip();
    rd(RFTC_TX_CTRL_ADDR, 8'h34);
    slip();
    rd(RFTC_TX_CTRL_ADDR, 8'h30);
    wait_lock();
    wr(RFTC_LOCK_CFG_ADDR, 8'h14);
    slip();
    slip();
    rd(RFTC_TX_CTRL_ADDR, 8'h34);
    wr(RFTC_LOCK_CFG_ADDR, 8'h04);
    slip();
    rd(RFTC_TX_CTRL_ADDR, 8'h30);
    wait_lock();
    $display("test slip_count done");
    // Key rising edge opens a blackout of eight reference ticks
    wr(RFTC_LOCK_CFG_ADDR, 8'h08);
    repeat (60) @(posedge clk);
    access(RFTC_OP_CLEAR, RFTC_TX_CTRL_ADDR, 3'h4, 8'h00);
    access(RFTC_OP_SET, RFTC_TX_CTRL_ADDR, 3'h4, 8'h00);
    slip();
    rd(RFTC_TX_CTRL_ADDR, 8'h34);
    repeat (60) @(posedge clk);
    slip();
    rd(RFTC_TX_CTRL_ADDR, 8'h30);
    wait_lock();
    $display("test blackout done");
    give_verdict();
  end
endmodule : rftc_regs_tb
